// >>> sfa_pkg.sv
// sfa_pkg: constants, register map and carrier types of the fabric-side
// transmit mux and receive alignment datapath. Assumes one 200 MHz clock.
// Operation
// - transmit lane carries a 32-bit word as four bytes, each with flags
// - per byte special flag selects data or control character encoding
// - transmit word and flags are taken on the fabric transmit strobe
// - forced flag emits positive code; otherwise disparity alternates
// - mux turns 40 bits into four 10-bit characters at byte rate
// - serializer takes one new character per internal byte tick
// - serializer input to serial output latency is five byte ticks
// - full or half rate selectable per channel for transmit and receive
// - each receive channel owns a 24 by 36-bit alignment FIFO
// - FIFO moves data to fabric domain, optional 2 or 4 channel groups
// - FIFO tolerates a combined skew budget of 230.4 ns
// - only decoded data and control flags are stored in the FIFO
// - alignment flag bit 3 of the top byte drives group synchronization
// - ungrouped channel sets write to start, read to middle on first flag
// - per channel minimum free space threshold raises group overflow, only for channels in a group
// - group counter loads 18, decrements by one after first alignment
// - once all channels seen, decrement by two until zero, then read
// - after out-of-sync the group rearms on the next flag; toggling the resync bit restarts alignment
// - clearing stream enable removes a channel without disturbing group
// - each group has a sticky overflow status bit
// - group out-of-sync set when counter hits zero before all arrived
// - returned block clock is selected byte tick divided by four
// - block clock select 0 picks first channel of its pair, 1 picks second
package sfa_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STREAM_EN = 8'h04;
   localparam logic [7:0] ADDR_MIN_SPACE = 8'h08;
   localparam logic [7:0] ADDR_STATUS    = 8'h0C;
   localparam logic [7:0] ADDR_INFO      = 8'h10;
   // ctrl fields
   localparam int CTRL_TX_FULL_POS = 0;
   localparam int CTRL_RX_FULL_POS = 4;
   localparam int CTRL_MODE_POS    = 8;
   localparam int CTRL_TXSEL_POS   = 10;
   localparam int CTRL_RESYNC_POS  = 12;
   // status fields
   localparam int STAT_FIFO_OVERFLOW_FLAG_POS    = 0;
   localparam int STAT_OOS_POS     = 4;
   localparam int STAT_DONE_POS    = 8;
   // reset values
   localparam logic [3:0]  RST_RATE_FULL = 4'hF;
   localparam logic [3:0]  RST_STREAM_EN = 4'hF;
   localparam logic [4:0]  RST_MIN_SPACE = 5'h02;
   // ==========================================================
   // timing
   localparam logic [1:0] TX_FULL_DIV = 2'h1;
   localparam logic [1:0] TX_HALF_DIV = 2'h3;
   localparam int SER_LAT      = 5;
   localparam int BYTES_PER_WORD = 4;
   localparam logic [4:0] SYNC_START = 5'h12;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SKEW_BUDGET_PS = 230400;
   localparam int SKEW_BUDGET_CYC = SKEW_BUDGET_PS / CLK_PERIOD_PS;
   localparam int FIFO_DEPTH = 24;
   localparam int FIFO_WIDTH = 36;
   localparam int NUM_CH = 4;
   localparam int NUM_GRP = 3;
   localparam logic [NUM_GRP-1:0][3:0] GRP_MASK = {4'hF, 4'hC, 4'h3};
   // ==========================================================
   // types
   typedef enum logic [1:0]
   {
      MODE_NONE = 2'b00,
      MODE_PAIR = 2'b01,
      MODE_QUAD = 2'b10
   } sfa_mode_t;
   typedef enum logic [1:0]
   {
      SY_WAIT  = 2'b00,
      SY_COUNT = 2'b01,
      SY_DONE  = 2'b10
   } sfa_sync_t;
   typedef struct packed
   {
      logic        valid;
      logic [31:0] tx_fabric_word;
      logic [3:0]  tx_special_char_flag;
      logic [3:0]  tx_force_neg_disparity;
   } sfa_tx_lane_t;
   typedef struct packed
   {
      logic        valid;
      logic [3:0]  rx_align_detect;
      logic [31:0] rx_decoded_word;
      logic [3:0]  rx_ctrl_char_flag;
   } sfa_rx_lane_t;
   typedef struct packed
   {
      logic        valid;
      logic [31:0] data;
      logic [3:0]  ctrl;
   } sfa_rx_out_t;
endpackage : sfa_pkg

// >>> sfa_align_fifo.sv
// sfa_align_fifo: one channel's alignment FIFO with realign pointer load.
// Assumes writes arrive as one-cycle enables on the single clock.
`timescale 1ns/10ps
`default_nettype none
module sfa_align_fifo
#(
   parameter int W     = 36,
   parameter int DEPTH = 24
)
(
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       nrst,
   // write side
   input  wire logic                       wr_en,
   input  wire logic [W-1:0]               wr_data,
   input  wire logic                       realign,
   input  wire logic                       mid_start,
   // read side
   input  wire logic                       rd_en,
   output logic                            rd_valid,
   output logic [W-1:0]                    rd_data,
   output logic [$clog2(DEPTH+1)-1:0]      count
);
   import sfa_pkg::*;
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   localparam logic [PW-1:0] MID  = PW'(DEPTH/2);
   localparam logic [PW-1:0] LAST = PW'(DEPTH-1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   initial if (DEPTH < 4 || DEPTH % 2 != 0) $error("fifo depth must be even and >= 4");
   typedef struct packed
   {
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [CW-1:0] count;
      logic          rd_valid;
      logic [W-1:0]  rd_data;
   } sfa_fifo_st_t;
   sfa_fifo_st_t s;
   sfa_fifo_st_t n;
   logic [W-1:0] mem [DEPTH];
   logic          do_wr;
   logic          do_rd;
   logic [PW-1:0] waddr;
   always_comb
   begin
      n = s;
      n.rd_valid = 1'b0;
      do_rd = rd_en && s.count != '0 && !realign;
      do_wr = wr_en && (realign || s.count != FULL);
      waddr = realign ? '0 : s.wptr;
      if (do_rd)
      begin
         n.rd_data  = mem[s.rptr];
         n.rd_valid = 1'b1;
         n.rptr     = (s.rptr == LAST) ? '0 : s.rptr + 1'b1;
      end
      if (realign)
      begin
         n.wptr  = PW'(1);
         n.rptr  = mid_start ? MID : '0;
         n.count = mid_start ? CW'(DEPTH - DEPTH/2 + 1) : CW'(1);
      end
      else
      begin
         if (do_wr)
            n.wptr = (s.wptr == LAST) ? '0 : s.wptr + 1'b1;
         n.count = s.count + CW'(do_wr) - CW'(do_rd);
      end
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         s <= '0;
      else
         s <= n;
   end
   // storage has no reset; after a mid_start realign, reads from MID onward run ahead of the write pointer
   always_ff @(posedge clock)
   begin
      if (do_wr)
         mem[waddr] <= wr_data;
   end
   assign rd_valid = s.rd_valid;
   assign rd_data  = s.rd_data;
   assign count    = s.count;
endmodule : sfa_align_fifo
`default_nettype wire

// >>> sfa_core.sv
// sfa_core: transmit byte mux with serializer delay line, and receive
// alignment FIFOs with group synchronizers, behind an APB register slave.
// Assumes all lane strobes are one-cycle enables on the 200 MHz clock.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sfa_core
#(
   parameter int NCH   = 4,
   parameter int DEPTH = 24
)
(
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         nrst,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   // fabric transmit lanes
   input  wire sfa_pkg::sfa_tx_lane_t [NCH-1:0] tx_in,
   output logic [NCH-1:0]                    tx_ready,
   output logic [NCH-1:0][9:0]               ser_char,
   output logic [NCH-1:0]                    internal_tx_byte_clock,
   output logic [1:0]                        returned_tx_block_clock,
   // receive lanes
   input  wire sfa_pkg::sfa_rx_lane_t [NCH-1:0] rx_in,
   output sfa_pkg::sfa_rx_out_t [NCH-1:0]    rx_out,
   output logic [NCH-1:0]                    rx_byte_tick
);
   import sfa_pkg::*;
   localparam int CW = $clog2(DEPTH+1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   initial if (NCH != NUM_CH) $error("group masks serve exactly four channels");
   initial if (DEPTH != FIFO_DEPTH || DEPTH > 31) $error("fifo depth must be 24");

   // ==========================================================
   // state
   typedef struct packed
   {
      logic [3:0]                    tx_full;
      logic [3:0]                    rx_full;
      sfa_mode_t                     mode;
      logic [1:0]                    tx_sel;
      logic                          resync;
      logic                          resync_q;
      logic [3:0]                    stream_en;
      logic [NCH-1:0][4:0]           min_space;
      logic [NUM_GRP-1:0]            fifo_overflow_flag;
      logic [NUM_GRP-1:0]            group_out_of_sync_flag;
      logic [31:0]                   prdata;
      logic [NCH-1:0][1:0]           tdiv;
      logic [NCH-1:0][1:0]           rdiv;
      logic [NCH-1:0][1:0]           phase;
      logic [NCH-1:0][39:0]          hold;
      logic [NCH-1:0]                hold_full;
      logic [NCH-1:0][39:0]          shift;
      logic [NCH-1:0]                disp;
      logic [NCH-1:0][SER_LAT:0][9:0] pipe;
      logic [NCH-1:0]                tick_q;
      logic [NCH-1:0]                rtick_q;
      logic [1:0]                    blk_q;
      logic [NCH-1:0]                solo;
      sfa_sync_t [NUM_GRP-1:0]       gst;
      logic [NUM_GRP-1:0][4:0]       cnt;
      logic [NUM_GRP-1:0][3:0]       seen;
   } sfa_st_t;
   sfa_st_t s;
   sfa_st_t n;

   logic [NCH-1:0]          realign;
   logic [NCH-1:0]          mid_start;
   logic [NCH-1:0]          rd_en;
   logic [NCH-1:0][CW-1:0]  fcount;
   logic [NCH-1:0]          al;
   logic [NCH-1:0]          in_grp;
   logic [NCH-1:0]          tick;
   logic [3:0]              member;
   logic [3:0]              newhit;
   logic [3:0]              seen_n;
   logic [NUM_GRP-1:0]      grp_on;
   logic [NUM_GRP-1:0]      fifo_overflow_flag_set;
   logic [NUM_GRP-1:0]      oos_set;
   logic [NUM_GRP-1:0]      done;
   logic [NUM_GRP-1:0]      st_clr;
   logic                    wr_acc;
   logic                    resync_evt;
   logic [39:0]             cur;
   logic [9:0]              chr;
   logic                    dbit;
   logic [1:0]              lim;
   logic [CW-1:0]           free;

   // ==========================================================
   // next state
   always_comb
   begin
      n = s;
      realign   = '0;
      mid_start = '0;
      rd_en     = '0;
      fifo_overflow_flag_set  = '0;
      oos_set   = '0;
      in_grp    = '0;
      member    = '0;
      newhit    = '0;
      seen_n    = '0;
      cur       = '0;
      chr       = '0;
      dbit      = 1'b0;
      lim       = '0;
      free      = '0;
      tick      = '0;
      st_clr    = '0;
      wr_acc    = psel && penable && pwrite;
      for (int g = 0; g < NUM_GRP; g++)
      begin
         done[g] = s.gst[g] == SY_DONE;
      end

      // apb read data is caught in the setup cycle so access needs no wait
      if (psel && !penable)
      begin
         case (paddr)
            ADDR_CTRL:
               n.prdata = 32'({s.resync, s.tx_sel, s.mode, s.rx_full, s.tx_full});
            ADDR_STREAM_EN:
               n.prdata = 32'(s.stream_en);
            ADDR_MIN_SPACE:
               n.prdata = 32'(s.min_space);
            ADDR_STATUS:
               n.prdata = 32'({1'b0, done, 1'b0, s.group_out_of_sync_flag, 1'b0, s.fifo_overflow_flag});
            ADDR_INFO:
               n.prdata = 32'(SKEW_BUDGET_CYC);
            default:
               n.prdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc)
      begin
         case (paddr)
            ADDR_CTRL:
            begin
               n.tx_full = pwdata[CTRL_TX_FULL_POS +: 4];
               n.rx_full = pwdata[CTRL_RX_FULL_POS +: 4];
               n.mode    = sfa_mode_t'(pwdata[CTRL_MODE_POS +: 2]);
               n.tx_sel  = pwdata[CTRL_TXSEL_POS +: 2];
               n.resync  = pwdata[CTRL_RESYNC_POS];
            end
            ADDR_STREAM_EN:
               n.stream_en = pwdata[3:0];
            ADDR_MIN_SPACE:
               n.min_space = pwdata[NCH*5-1:0];
            ADDR_STATUS:
            begin
               st_clr = pwdata[STAT_FIFO_OVERFLOW_FLAG_POS +: NUM_GRP] | pwdata[STAT_OOS_POS +: NUM_GRP];
            end
            default:
               n.prdata = s.prdata;
         endcase
      end

      // ==========================================================
      // transmit path
      for (int c = 0; c < NCH; c++)
      begin
         lim = s.tx_full[c] ? TX_FULL_DIV : TX_HALF_DIV;
         tick[c] = s.tdiv[c] >= lim;
         n.tdiv[c] = tick[c] ? 2'h0 : s.tdiv[c] + 2'h1;
         n.tick_q[c] = tick[c];
         lim = s.rx_full[c] ? TX_FULL_DIV : TX_HALF_DIV;
         n.rtick_q[c] = s.rdiv[c] >= lim;
         n.rdiv[c] = (s.rdiv[c] >= lim) ? 2'h0 : s.rdiv[c] + 2'h1;
         if (tick[c])
         begin
            // word split into characters, top byte first
            if (s.phase[c] == 2'h0)
            begin
               cur = s.hold_full[c] ? s.hold[c] : 40'h00_0000_0000;
               n.hold_full[c] = 1'b0;
            end
            else
            begin
               cur = s.shift[c];
            end
            dbit = cur[38] ? 1'b1 : !s.disp[c];
            n.disp[c] = dbit;
            chr = {cur[39], dbit, cur[37:30]};
            n.shift[c] = {cur[29:0], 10'h000};
            n.phase[c] = s.phase[c] + 2'h1;
            // five tick delay line to serial output
            n.pipe[c] = {s.pipe[c][SER_LAT-1:0], chr};
         end
         if (tx_in[c].valid && !s.hold_full[c])
         begin
            n.hold_full[c] = 1'b1;
            for (int b = 0; b < BYTES_PER_WORD; b++)
            begin
               // each byte travels with its own flags
               n.hold[c][b*10 +: 10] = {tx_in[c].tx_special_char_flag[b],
                                        tx_in[c].tx_force_neg_disparity[b],
                                        tx_in[c].tx_fabric_word[b*8 +: 8]};
            end
         end
      end
      for (int b = 0; b < 2; b++)
      begin
         // divide selected byte tick by four
         n.blk_q[b] = s.tx_sel[b] ? (tick[2*b+1] && s.phase[2*b+1] == 2'h3)
                                  : (tick[2*b] && s.phase[2*b] == 2'h3);
      end

      // ==========================================================
      // receive synchronizers
      // toggling resync or leaving group mode restarts synchronization
      resync_evt = s.resync != s.resync_q;
      n.resync_q = s.resync;
      for (int c = 0; c < NCH; c++)
      begin
         // bit 3 marks the alignment character
         al[c] = rx_in[c].valid && rx_in[c].rx_align_detect[3];
      end
      grp_on = {s.mode == MODE_QUAD, s.mode == MODE_PAIR, s.mode == MODE_PAIR};
      for (int g = 0; g < NUM_GRP; g++)
      begin
         member = GRP_MASK[g] & s.stream_en & {4{grp_on[g]}};
         in_grp = in_grp | member;
         newhit = al & member & ~s.seen[g];
         seen_n = s.seen[g] | newhit;
         case (s.gst[g])
            SY_WAIT:
            begin
               n.cnt[g] = SYNC_START;
               if (newhit != 4'h0)
               begin
                  realign = realign | newhit;
                  n.seen[g] = newhit;
                  n.gst[g] = SY_COUNT;
               end
            end
            SY_COUNT:
            begin
               realign = realign | newhit;
               n.seen[g] = seen_n;
               if (s.cnt[g] == 5'h00)
               begin
                  if ((seen_n & member) == member)
                  begin
                     n.gst[g] = SY_DONE;
                  end
                  else
                  begin
                     // counter expired short of a channel
                     oos_set[g] = 1'b1;
                     n.gst[g] = SY_WAIT;
                     n.seen[g] = 4'h0;
                  end
               end
               // step of two once every channel arrived
               else if ((seen_n & member) == member)
                  n.cnt[g] = (s.cnt[g] < 5'h02) ? 5'h00 : s.cnt[g] - 5'h02;
               else
                  n.cnt[g] = s.cnt[g] - 5'h01;
            end
            SY_DONE:
            begin
               for (int c = 0; c < NCH; c++)
               begin
                  rd_en[c] = rd_en[c] | (member[c] && fcount[c] != '0);
               end
            end
            default:
               n.gst[g] = SY_WAIT;
         endcase
         if (resync_evt || !grp_on[g])
         begin
            n.gst[g]  = SY_WAIT;
            n.cnt[g]  = SYNC_START;
            n.seen[g] = 4'h0;
         end
         for (int c = 0; c < NCH; c++)
         begin
            free = DEPTH_C - fcount[c];
            if (member[c] && free < CW'(s.min_space[c]))
               fifo_overflow_flag_set[g] = 1'b1;
         end
      end
      for (int c = 0; c < NCH; c++)
      begin
         if (in_grp[c] || resync_evt)
         begin
            n.solo[c] = 1'b0;
         end
         else if (!s.solo[c] && al[c])
         begin
            realign[c]   = 1'b1;
            mid_start[c] = 1'b1;
            n.solo[c]    = 1'b1;
         end
         else if (s.solo[c])
         begin
            rd_en[c] = fcount[c] != '0;
         end
      end
      // sticky until cleared; a new event wins over the clear
      n.fifo_overflow_flag = (s.fifo_overflow_flag & ~st_clr) | fifo_overflow_flag_set;
      n.group_out_of_sync_flag  = (s.group_out_of_sync_flag & ~st_clr) | oos_set;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         s           <= '0;
         s.tx_full   <= RST_RATE_FULL;
         s.rx_full   <= RST_RATE_FULL;
         s.stream_en <= RST_STREAM_EN;
         s.min_space <= {NCH{RST_MIN_SPACE}};
         s.cnt       <= {NUM_GRP{SYNC_START}};
      end
      else
      begin
         s <= n;
      end
   end

   // ==========================================================
   // alignment FIFOs
   // one FIFO per channel
   for (genvar c = 0; c < NCH; c++)
   begin : g_fifo
      logic [FIFO_WIDTH-1:0] rdata;
      sfa_align_fifo
      #(
         .W     (FIFO_WIDTH),
         .DEPTH (DEPTH)
      )
      u_fifo
      (
         .clock     (clock),
         .nrst      (nrst),
         .wr_en     (rx_in[c].valid),
         .wr_data   ({rx_in[c].rx_decoded_word, rx_in[c].rx_ctrl_char_flag}),
         .realign   (realign[c]),
         .mid_start (mid_start[c]),
         .rd_en     (rd_en[c]),
         .rd_valid  (rx_out[c].valid),
         .rd_data   (rdata),
         .count     (fcount[c])
      );
      assign rx_out[c].data = rdata[35:4];
      assign rx_out[c].ctrl = rdata[3:0];
      assign ser_char[c] = s.pipe[c][SER_LAT];
   end

   // fabric must stay locked to the returned clock
   assign tx_ready                = ~s.hold_full;
   assign internal_tx_byte_clock  = s.tick_q;
   assign returned_tx_block_clock = s.blk_q;
   assign rx_byte_tick            = s.rtick_q;
   assign prdata                  = s.prdata;
   assign pready                  = 1'b1;
   assign pslverr = psel && penable && paddr > ADDR_INFO;
endmodule : sfa_core
`default_nettype wire

// >>> sfa_core_properties.sv
// sfa_core_properties: port-level checks of sfa_core.
// Assumes a bind into sfa_core; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module sfa_core_properties
#(
   parameter int NCH = 4
)
(
   // clock and reset
   input wire logic                            clock,
   input wire logic                            nrst,
   // apb
   input wire logic                            psel,
   input wire logic                            penable,
   input wire logic [7:0]                      paddr,
   input wire logic                            pready,
   input wire logic                            pslverr,
   // transmit
   input wire sfa_pkg::sfa_tx_lane_t [NCH-1:0] tx_in,
   input wire logic [NCH-1:0]                  tx_ready,
   input wire logic [NCH-1:0]                  internal_tx_byte_clock,
   input wire logic [1:0]                      returned_tx_block_clock
);
   import sfa_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // ==========
   chk_apb_ready: assert property (pready)
      else $error("pready low");
   chk_apb_slverr: assert property (pslverr == (psel && penable && paddr > 8'h10))
      else $error("pslverr wrong");
   chk_tx_take: assert property (tx_in[0].valid && tx_ready[0] |=> !tx_ready[0])
      else $error("word not taken");
   chk_hold_free: assert property ($fell(tx_ready[0]) |-> ##[1:16] tx_ready[0])
      else $error("hold never empties");
   chk_tick_gap: assert property (internal_tx_byte_clock[0] |=> !internal_tx_byte_clock[0])
      else $error("byte tick too long");
   chk_tick_period: assert property
      (internal_tx_byte_clock[0] |-> ##[2:4] internal_tx_byte_clock[0])
      else $error("byte tick period wrong");
   chk_blk_gap: assert property
      (returned_tx_block_clock[0] |=> !returned_tx_block_clock[0] [*7])
      else $error("block clock too fast");
   chk_blk_period: assert property
      (returned_tx_block_clock[0] |-> ##[8:16] returned_tx_block_clock[0])
      else $error("block clock too slow");
endmodule : sfa_core_properties
`default_nettype wire

// >>> sfa_fabric_model.sv
// sfa_fabric_model: fabric logic sending words on transmit lane 0.
// Assumes the returned block clock pulse paces each word.
`timescale 1ns/10ps
`default_nettype none
module sfa_fabric_model
(
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          nrst,
   // bench request
   input  wire logic                          go,
   input  wire logic [31:0]                   word,
   input  wire logic [3:0]                    spec,
   input  wire logic [3:0]                    force_neg,
   // core side
   input  wire logic                          blk,
   input  wire logic                          ready,
   output var sfa_pkg::sfa_tx_lane_t [3:0]    tx_in
);
   import sfa_pkg::*;
   logic pend;
   // whole word, paced by block clock
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pend <= 1'b0;
         tx_in <= '0;
      end
      else
      begin
         tx_in <= '0;
         if (go)
            pend <= 1'b1;
         else if (pend && blk && ready)
         begin
            pend <= 1'b0;
            tx_in[0] <= {1'b1, word, spec, force_neg};
         end
      end
   end
endmodule : sfa_fabric_model
`default_nettype wire

// >>> sfa_core_tb.sv
// sfa_core_tb: register, transmit and alignment tests of sfa_core.
// Assumes sfa_fabric_model feeds lane 0; bench drives receive lanes.
`timescale 1ns/10ps
`default_nettype none
module sfa_core_tb;
   import sfa_pkg::*;
   logic clock, nrst, psel, penable, pwrite, pready, pslverr, go, got;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, word;
   logic [3:0] tx_ready, tick, rxt, spec, fneg;
   logic [3:0][9:0] ser_char;
   logic [1:0] blk;
   sfa_tx_lane_t [3:0] tx_in;
   sfa_rx_lane_t [3:0] rx_in;
   sfa_rx_out_t [3:0] rx_out;
   logic [9:0] chars[$];
   logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] rv[6] = '{32'hFF, 32'hF, 32'h10842, 32'h0, 32'h2E, 32'h0};
   int fails, n_tests;
   sfa_core #(.NCH(4), .DEPTH(24)) dut (.clock(clock), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_in(tx_in), .tx_ready(tx_ready),
      .ser_char(ser_char), .internal_tx_byte_clock(tick), .returned_tx_block_clock(blk),
      .rx_in(rx_in), .rx_out(rx_out), .rx_byte_tick(rxt));
   sfa_fabric_model fab (.clock(clock), .nrst(nrst), .go(go), .word(word), .spec(spec),
      .force_neg(fneg), .blk(blk[0]), .ready(tx_ready[0]), .tx_in(tx_in));
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // log every new character on lane 0
   always @(posedge clock)
      if (chars.size() == 0 || ser_char[0] !== chars[$])
         chars.push_back(ser_char[0]);
   always @(posedge clock)
      if (rx_out[0].valid === 1'b1 && {rx_out[0].data, rx_out[0].ctrl} === 36'hBC0000AA8)
         got <= 1'b1;
   // ==========
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rx_put(input logic [3:0] m, input logic [3:0] al, input logic [35:0] dk);
      @(posedge clock);
      for (int c = 0; c < 4; c++)
         rx_in[c] <= m[c] ? {1'b1, al, dk} : '0;
      @(posedge clock);
      rx_in <= '0;
   endtask : rx_put
   task automatic tx_send(input logic [31:0] w, input logic [3:0] k, input logic [3:0] f);
      int i;
      i = -1;
      word <= w;
      spec <= k;
      fneg <= f;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      chars.delete();
      repeat (80) @(posedge clock);
      for (int j = 0; j + 3 < chars.size(); j++)
         if (i < 0 && {chars[j][9], chars[j][7:0]} === {k[3], w[31:24]})
            i = j;
      chk("tx_found", i >= 0, 1);
      for (int b = 0; b < 4 && i >= 0; b++)
      begin
         chk("tx_char", {chars[i+b][9], chars[i+b][7:0]}, {k[3-b], w[31-8*b -: 8]});
         if (f[3-b])
            chk("tx_disp", chars[i+b][8], 1);
         else if (b > 0)
            chk("tx_disp", chars[i+b][8], !chars[i+b-1][8]);
      end
   endtask : tx_send
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      repeat (8) @(posedge clock);
      do @(posedge clock); while ((tick[0] & rxt[0]) !== 1'b1);
      do
      begin
         @(posedge clock);
         n++;
      end while ((tick[0] & rxt[0]) !== 1'b1);
      chk("tick_gap", n, exp);
   endtask : tick_gap
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   initial
   begin
      #200000;
      fails++;
      give_verdict();
   end
   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata, go, got, word, spec, fneg} = '0;
      {rx_in, fails, n_tests} = '0;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      foreach (ra[i])
      begin
         apb(1'b0, ra[i], 32'h0);
         chk("reg", rd, rv[i]);
      end
      tx_send(32'hA1B2C3D4, 4'h8, 4'h4);
      tx_send(32'h1F2E3D4C, 4'h1, 4'h3);
      apb(1'b1, ADDR_CTRL, 32'hEE);
      tick_gap(4);
      apb(1'b1, ADDR_CTRL, 32'hFF);
      tick_gap(2);
      // ungrouped lane realigns on its first alignment flag
      rx_put(4'h1, 4'h8, 36'hBC0000AA8);
      for (int i = 0; i < 20; i++)
         rx_put(4'h1, 4'h0, 36'(i));
      repeat (20) @(posedge clock);
      chk("rx_word", got, 1);
      apb(1'b1, ADDR_CTRL, 32'h2FF);
      apb(1'b1, ADDR_CTRL, 32'h12FF);
      rx_put(4'h1, 4'h8, 36'h0);
      repeat (40) @(posedge clock);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("oos", rd, 32'h40);
      apb(1'b1, ADDR_STATUS, 32'h40);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("oos_clr", rd, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h2FF);
      rx_put(4'hF, 4'h8, 36'h0);
      repeat (40) @(posedge clock);
      rx_put(4'h1, 4'h8, 36'h0);
      repeat (40) @(posedge clock);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("done", rd, 32'h400);
      apb(1'b1, ADDR_MIN_SPACE, 32'hFFFFF);
      repeat (4) @(posedge clock);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("fifo_overflow_flag", rd, 32'h404);
      give_verdict();
   end
endmodule : sfa_core_tb
bind sfa_core sfa_core_properties #(.NCH(NCH)) u_props (.clock(clock), .nrst(nrst),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .tx_in(tx_in), .tx_ready(tx_ready), .internal_tx_byte_clock(internal_tx_byte_clock),
   .returned_tx_block_clock(returned_tx_block_clock));
`default_nettype wire
